// *** hdl/pic_top.sv ***
/*
 * fixed-priority interrupt controller with request latches, enable
 * register and vector selection. assumes peripherals give one-cycle
 * request pulses on REF_CLK, a machine-cycle enable from the core.
 */
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
(
    input  wire logic        REF_CLK,     // system clock
    input  wire logic        NRST,        // async reset, low
    input  wire logic        MCYC_EN,     // machine cycle enable pulse
    input  wire logic [15:0] REQ_IN,      // request pulses, bit n source n
    input  wire logic        EXT0_EN_CTL, // dedicated ext 0 enable
    input  wire pic_cpu_s    CPU_EV,      // core instruction events
    input  wire logic [7:0]  SFR_ADDR,    // sfr byte address
    input  wire logic [7:0]  SFR_WDATA,   // write data
    input  wire logic        SFR_WR,      // byte write strobe
    input  wire logic        SFR_WR16,    // word write, low at SFR_ADDR
    input  wire logic [15:0] SFR_WDATA16, // word write data
    output logic [15:0] SFR_RDATA,        // read data, low byte at SFR_ADDR
    output logic        ACCEPT_START,     // pulse when acceptance begins
    output logic        ACCEPT_DONE,      // pulse, vector valid, 8 mcyc later
    output logic [15:0] VECTOR,           // vector table address
    output logic        NMI_ACTIVE        // pseudo nmi service active
);
    // ****************************************
    // functions
    // ****************************************
    // highest priority is the lowest set bit
    function automatic logic [3:0] pic_pick(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) r = 4'(i);
        end
        return r;
    endfunction

    function automatic logic [15:0] pic_vec(input logic [3:0] n);
        return PIC_RESET_VEC - {11'h000, n, 1'b0};
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [15:0] latch_q, latch_d;
    logic [15:0] en_q, en_d;
    logic        nmi_q, nmi_d;
    logic        mst_save_q, mst_save_d;
    logic        trap_q, trap_d;
    pic_state_e  state_q, state_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [3:0]  src_q, src_d;
    logic [15:0] rdata_q;
    logic        start_q, done_q;
    logic [15:0] vec_q;

    // ****************************************
    // decode and eligibility
    // ****************************************
    wire logic        wr_en_lo = SFR_WR && SFR_ADDR == PIC_ADDR_EN_LO;
    wire logic        wr_en_hi = SFR_WR && SFR_ADDR == PIC_ADDR_EN_HI;
    wire logic        wr_rl_lo = SFR_WR && SFR_ADDR == PIC_ADDR_RL_LO;
    wire logic        wr_rl_hi = SFR_WR && SFR_ADDR == PIC_ADDR_RL_HI;
    wire logic        w16_en   = SFR_WR16 && SFR_ADDR == PIC_ADDR_EN_LO;
    wire logic        w16_rl   = SFR_WR16 && SFR_ADDR == PIC_ADDR_RL_LO;
    wire logic        mstr_en  = en_q[PIC_MASTER_BIT];
    // software writes only clear latches: zero bits clear, one bits keep
    wire logic [15:0] wr_keep  = w16_rl ? SFR_WDATA16 :
                                 wr_rl_lo ? {8'hFF, SFR_WDATA} :
                                 wr_rl_hi ? {SFR_WDATA, 8'hFF} : 16'hFFFF;
    // ext 0 gated by its dedicated control, not an enable-register bit
    wire logic [15:0] maskable = {en_q[15:4], EXT0_EN_CTL, 3'b000}
                                 & {16{mstr_en}};
    wire logic [15:0] nmi_ok   = {13'h0000, ~nmi_q, ~nmi_q, 1'b0};
    wire logic [15:0] trap_vec = {14'h0000, trap_q, 1'b0};
    wire logic [15:0] eligible = ((latch_q & (maskable | nmi_ok)) | (trap_vec & nmi_ok))
                                 & (PIC_RL_MASK | 16'h0002);
    wire logic        any_req  = |eligible;
    // sampling only in the instruction's last cycle
    wire logic        take     = state_q == PIC_IDLE && CPU_EV.instr_last && any_req;
    wire logic [3:0]  pick     = pic_pick(eligible);
    wire logic        pick_nmi = pick == 4'(PIC_TRAP_PRI) || pick == 4'(PIC_WDT_PRI);
    wire logic        done     = state_q == PIC_ACCEPT && MCYC_EN && cnt_q == 4'h1;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        // set from a source wins over a software clear in the same cycle
        latch_d = ((latch_q & wr_keep) | REQ_IN) & PIC_RL_MASK;
        // the trap has no latch, so its tied-off bit must stay clear here too
        if (take) latch_d[pick] = REQ_IN[pick] & PIC_RL_MASK[pick];
        en_d = en_q;
        if (w16_en) en_d = SFR_WDATA16;
        if (wr_en_lo) en_d[7:0] = SFR_WDATA;
        if (wr_en_hi) en_d[15:8] = SFR_WDATA;
        if (CPU_EV.irq_on) en_d[PIC_MASTER_BIT] = 1'b1;
        if (CPU_EV.irq_off) en_d[PIC_MASTER_BIT] = 1'b0;
        if (CPU_EV.ret_mask) en_d[PIC_MASTER_BIT] = 1'b1;
        if (CPU_EV.ret_nmi) en_d[PIC_MASTER_BIT] = mst_save_q;
        if (take) en_d[PIC_MASTER_BIT] = 1'b0;
        en_d = en_d & PIC_EN_MASK;
        // trap instruction is a nop during nmi service
        trap_d = (trap_q | (CPU_EV.trap && !nmi_q)) && !(take && pick == 4'(PIC_TRAP_PRI));
        nmi_d = nmi_q;
        mst_save_d = mst_save_q;
        if (CPU_EV.ret_nmi) nmi_d = 1'b0;
        if (take && pick_nmi) begin
            nmi_d = 1'b1;
            mst_save_d = mstr_en;
        end
        state_d = state_q;
        cnt_d = cnt_q;
        src_d = src_q;
        case (state_q)
            PIC_IDLE: begin
                if (take) begin
                    state_d = PIC_ACCEPT;
                    cnt_d = PIC_ACCEPT_CNT;
                    src_d = pick;
                end
            end
            PIC_ACCEPT: begin
                if (MCYC_EN) cnt_d = cnt_q - 4'h1;
                if (done) state_d = PIC_IDLE;
            end
            default: state_d = PIC_IDLE;
        endcase
    end

    // read mux: current latch and enable state
    wire logic [15:0] rd_word = (SFR_ADDR == PIC_ADDR_EN_LO) ? en_q :
                                (SFR_ADDR == PIC_ADDR_EN_HI) ? {8'h00, en_q[15:8]} :
                                (SFR_ADDR == PIC_ADDR_RL_LO) ? latch_q :
                                (SFR_ADDR == PIC_ADDR_RL_HI) ? {8'h00, latch_q[15:8]} :
                                16'h0000;

    // ****************************************
    // registers
    // ****************************************
    // reset clears every latch; ext 3 undefined value is chosen as zero
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            latch_q    <= PIC_RL_RST;
            en_q       <= PIC_EN_RST;
            nmi_q      <= 1'b0;
            mst_save_q <= 1'b0;
            trap_q     <= 1'b0;
            state_q    <= PIC_IDLE;
            cnt_q      <= 4'h0;
            src_q      <= 4'h0;
        end else begin
            latch_q    <= latch_d;
            en_q       <= en_d;
            nmi_q      <= nmi_d;
            mst_save_q <= mst_save_d;
            trap_q     <= trap_d;
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            src_q      <= src_d;
        end
    end

    // registered outputs
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 16'h0000;
            start_q <= 1'b0;
            done_q  <= 1'b0;
            vec_q   <= PIC_RESET_VEC;
        end else begin
            rdata_q <= rd_word;
            start_q <= take;
            done_q  <= done;
            if (done) vec_q <= pic_vec(src_q);
        end
    end

    assign SFR_RDATA    = rdata_q;
    assign ACCEPT_START = start_q;
    assign ACCEPT_DONE  = done_q;
    assign VECTOR       = vec_q;
    assign NMI_ACTIVE   = nmi_q;
endmodule // pic_top

// *** hdl/pic_pkg.sv ***
/*
 * constants, types and notes for the prioritized interrupt controller.
 * assumes a single 200 MHz clock and a cpu sequencer on the same clock.
 */
package pic_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] PIC_ADDR_EN_LO  = 8'h3A;
    localparam logic [7:0] PIC_ADDR_EN_HI  = 8'h3B;
    localparam logic [7:0] PIC_ADDR_RL_LO  = 8'h3C;
    localparam logic [7:0] PIC_ADDR_RL_HI  = 8'h3D;
    localparam logic [15:0] PIC_EN_RST     = 16'h0000;
    localparam logic [15:0] PIC_EN_MASK    = 16'hFFF1; // bits 3..1 unimplemented
    localparam logic [15:0] PIC_RL_MASK    = 16'hFFDC; // bits 1,0 and source 5 tied off
    localparam logic [15:0] PIC_RL_RST     = 16'h0000;
    localparam int          PIC_MASTER_BIT = 0;
    localparam int          PIC_TRAP_PRI   = 1;
    localparam int          PIC_WDT_PRI    = 2;
    localparam int          PIC_EXT0_PRI   = 3;
    localparam logic [15:0] PIC_RESET_VEC  = 16'hFFFE;
    // ****************************************
    // timing
    // ****************************************
    localparam int          PIC_ACCEPT_MCYC = 8;
    localparam logic [3:0]  PIC_ACCEPT_CNT  = 4'h8;

    typedef enum logic [1:0] {
        PIC_IDLE   = 2'b00,
        PIC_ACCEPT = 2'b01
    } pic_state_e;

    // cpu sequencer event strobes
    typedef struct packed {
        logic instr_last;  // last cycle of an instruction
        logic trap;        // software trap instruction executed
        logic ret_mask;    // maskable return
        logic ret_nmi;     // nmi return
        logic irq_on;      // enable instruction
        logic irq_off;     // disable instruction
    } pic_cpu_s;
endpackage

// *** dv/pic_checker.sv ***
/* checker: port relations of the interrupt controller.
   assumes it is bound into pic_top and sees only its ports. */
`timescale 1ns/1ps
module pic_checker
    import pic_pkg::*;
(
    input wire logic        REF_CLK,      // system clock
    input wire logic        NRST,         // async reset, low
    input wire pic_cpu_s    CPU_EV,       // core events
    input wire logic [7:0]  SFR_ADDR,     // read address
    input wire logic [15:0] SFR_RDATA,    // read data
    input wire logic        ACCEPT_START, // acceptance begins
    input wire logic        ACCEPT_DONE,  // vector valid
    input wire logic [15:0] VECTOR,       // vector address
    input wire logic        NMI_ACTIVE    // pseudo nmi in service
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // acceptance timing: only at an instruction end, never faster than eight cycles
    a_take_at_last: assert property (ACCEPT_START |-> $past(CPU_EV.instr_last))
        else $error("acceptance outside last cycle");
    a_accept_len: assert property (ACCEPT_START |=> !ACCEPT_DONE [*7] ##[1:100] ACCEPT_DONE)
        else $error("acceptance length wrong");
    a_start_once: assert property (ACCEPT_START |=> !ACCEPT_START [*8])
        else $error("overlapping acceptance");
    // vectors: even, inside the table, reset vector only out of reset
    a_vec_table: assert property (ACCEPT_DONE |-> !VECTOR[0] && VECTOR >= 16'hFFE0 && VECTOR != 16'hFFFE)
        else $error("vector outside table");
    a_vec_reset: assert property ($rose(NRST) |-> VECTOR == 16'hFFFE)
        else $error("reset vector wrong");
    a_nmi_flag: assert property (ACCEPT_DONE && VECTOR inside {16'hFFFA, 16'hFFFC} |-> NMI_ACTIVE)
        else $error("nmi service not flagged");
    // read-back: data lags the address by one cycle
    a_rd_unmapped: assert property (!(SFR_ADDR inside {[8'h3A:8'h3D]}) |=> SFR_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_en_unimpl: assert property (SFR_ADDR == 8'h3A |=> SFR_RDATA[3:1] == 3'h0)
        else $error("unimplemented enable bits set");
    a_rl_tied: assert property (SFR_ADDR == 8'h3C |=> SFR_RDATA[1:0] == 2'h0 && !SFR_RDATA[5])
        else $error("tied latch bit set");
    a_byte_read: assert property (SFR_ADDR inside {8'h3B, 8'h3D} |=> SFR_RDATA[15:8] == 8'h00)
        else $error("byte read upper bits set");
endmodule // pic_checker

bind pic_top pic_checker u_chk (.REF_CLK, .NRST, .CPU_EV, .SFR_ADDR, .SFR_RDATA,
    .ACCEPT_START, .ACCEPT_DONE, .VECTOR, .NMI_ACTIVE);

// *** dv/pic_cpu_model.sv ***
/* cpu sequencer model: machine-cycle and instruction-end pulses.
   assumes one clock; changes land on falling edges. */
`timescale 1ns/1ps
module pic_cpu_model (
    input  wire logic clk,     // system clock
    input  wire logic rst_n,   // reset, low
    output logic      mcyc_en, // machine cycle pulse
    output logic      last     // instruction last cycle
);
    logic [2:0] cnt_q;
    // two clocks a machine cycle, four machine cycles an instruction
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 3'h0;
        else cnt_q <= cnt_q + 3'h1;
    end
    assign mcyc_en = cnt_q[0];
    assign last    = (cnt_q == 3'h7); // sampling point for requests
endmodule // pic_cpu_model

// *** dv/testbench.sv ***
/* testbench: registers, priority and acceptance of pic_top.
   assumes the cpu model paces machine cycles and instruction ends. */
`timescale 1ns/1ps
module testbench;
    logic REF_CLK = 0, NRST = 0, EXT0_EN_CTL = 0, wr = 0, wr16 = 0, mc, lst;
    logic ACCEPT_START, ACCEPT_DONE, NMI_ACTIVE;
    logic [4:0]  ev = '0; // trap, ret_mask, ret_nmi, irq_on, irq_off
    logic [7:0]  addr = '0, wd8 = '0;
    logic [15:0] req = '0, wd16 = '0, SFR_RDATA, VECTOR;
    pic_pkg::pic_cpu_s cpu_ev;
    int num_errors = 0, compares = 0, cycles = 0;
    always #2.5 REF_CLK = ~REF_CLK;
    assign cpu_ev = {lst, ev};
    pic_cpu_model u_cpu (.clk(REF_CLK), .rst_n(NRST), .mcyc_en(mc), .last(lst));
    pic_top u_dut (.REF_CLK, .NRST, .MCYC_EN(mc), .REQ_IN(req), .EXT0_EN_CTL,
        .CPU_EV(cpu_ev), .SFR_ADDR(addr), .SFR_WDATA(wd8), .SFR_WR(wr), .SFR_WR16(wr16),
        .SFR_WDATA16(wd16), .SFR_RDATA, .ACCEPT_START, .ACCEPT_DONE, .VECTOR, .NMI_ACTIVE);
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // every drive starts after a falling edge and is held over one rising edge
    task automatic wr_r(input logic [7:0] a, input logic [15:0] d, input bit w);
        addr = a;
        wd8 = d[7:0];
        wd16 = d;
        wr = !w;
        wr16 = w;
        @(negedge REF_CLK);
        wr = 0;
        wr16 = 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        addr = a;
        @(negedge REF_CLK);
        chk(SFR_RDATA, exp);
    endtask
    task automatic pulse(input logic [15:0] r, input logic [4:0] e);
        req = r;
        ev = e;
        @(negedge REF_CLK);
        req = '0;
        ev = '0;
        @(negedge REF_CLK); // idle cycle: back-to-back pulses never retoggle in one step
    endtask
    // zero means no acceptance may complete within the window
    task automatic wait_acc(input logic [15:0] v);
        int n = 0;
        while (ACCEPT_DONE !== 1'b1 && n < 60) begin
            @(negedge REF_CLK);
            n++;
        end
        chk(ACCEPT_DONE === 1'b1 ? VECTOR : 16'h0000, v);
    endtask
    // hang guard: the sequence needs under a thousand cycles
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(negedge REF_CLK);
        NRST = 1;
        chk(VECTOR, 16'hFFFE);
        rd_chk(8'h3A, 16'h0000);
        rd_chk(8'h3C, 16'h0000);
        rd_chk(8'h40, 16'h0000);
        wr_r(8'h3A, 16'hFFFF, 1);
        rd_chk(8'h3A, 16'hFFF1);
        rd_chk(8'h3B, 16'h00FF);
        wr_r(8'h3A, 16'h0000, 1);
        pulse(16'h8070, 5'h00);
        rd_chk(8'h3C, 16'h8050);
        wr_r(8'h3D, 16'h007F, 0);
        rd_chk(8'h3C, 16'h0050);
        wr_r(8'h3C, 16'hFFFF, 1);
        rd_chk(8'h3C, 16'h0050);
        wr_r(8'h3A, 16'h0050, 1);
        wait_acc(16'h0000);
        pulse(16'h0000, 5'h02);
        wait_acc(16'hFFF6);
        rd_chk(8'h3C, 16'h0040);
        rd_chk(8'h3A, 16'h0050);
        pulse(16'h0000, 5'h08);
        wait_acc(16'hFFF2);
        pulse(16'h0000, 5'h02);
        rd_chk(8'h3A, 16'h0051);
        pulse(16'h0000, 5'h01);
        rd_chk(8'h3A, 16'h0050);
        pulse(16'h0008, 5'h02);
        wait_acc(16'h0000);
        EXT0_EN_CTL = 1;
        wait_acc(16'hFFF8);
        pulse(16'h0004, 5'h00);
        wait_acc(16'hFFFA);
        chk({15'h0000, NMI_ACTIVE}, 16'h0001);
        pulse(16'h0000, 5'h10);
        wait_acc(16'h0000);
        pulse(16'h0000, 5'h04);
        rd_chk(8'h3A, 16'h0050);
        chk({15'h0000, NMI_ACTIVE}, 16'h0000);
        pulse(16'h0000, 5'h02);
        pulse(16'h0000, 5'h10);
        wait_acc(16'hFFFC);
        pulse(16'h0004, 5'h00);
        wait_acc(16'h0000);
        pulse(16'h0000, 5'h04);
        wait_acc(16'hFFFA);
        pulse(16'h0000, 5'h04);
        rd_chk(8'h3A, 16'h0051);
        // mid-run reset with a latch pending and the master flag set
        pulse(16'h1000, 5'h00);
        rd_chk(8'h3D, 16'h0010);
        NRST = 0;
        repeat (2) @(negedge REF_CLK);
        NRST = 1;
        chk(VECTOR, 16'hFFFE);
        rd_chk(8'h3C, 16'h0000);
        rd_chk(8'h3A, 16'h0000);
        report_and_stop();
    end
endmodule // testbench
